// *** verilog/fir_link_pkg.sv ***
package fir_link_pkg;
	// ------------------------------------------------------------
	// register map (word addresses on the 7-bit host port)
	// ------------------------------------------------------------
	localparam logic [6:0] SHADOW_BASE = 7'h00;
	localparam logic [6:0] LIVE_BASE = 7'h20;
	localparam logic [6:0] STATIC_CONFIG_ADDR = 7'h40;
	localparam logic [6:0] ACTIVE_CONTROL_ADDR = 7'h42;
	localparam logic [6:0] TEST_CONTROL_ADDR = 7'h44;
	localparam logic [6:0] SAMPLE_INPUT_ADDR = 7'h48;
	localparam logic [6:0] RESULT_LOW_ADDR = 7'h4a;
	localparam logic [6:0] RESULT_HIGH_ADDR = 7'h4b;
	localparam logic [6:0] MIRROR_MASK = 7'h4f;
	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int CFG_MASTER_BIT = 0;
	localparam int CFG_SOURCE_BIT = 1;
	localparam int CFG_SWAP_CONT_BIT = 2;
	localparam int CFG_FAST_BIT = 10;
	localparam int CFG_SIZE_LSB = 8;
	localparam logic [15:0] STATIC_CONFIG_RESET = 16'h0320;
	localparam logic [15:0] ACTIVE_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] TEST_CONTROL_RESET = 16'h0000;
	localparam int ACTIVE_SWAP_BIT = 0;
	// ------------------------------------------------------------
	// widths and timing
	// ------------------------------------------------------------
	localparam int SAMPLE_WIDTH = 16;
	localparam int HALF_WIDTH = 12;
	localparam int RESULT_WIDTH = 24;
	localparam int TAP_COUNT = 32;
	localparam int SETTLE_CYCLES = 20;
	localparam int SYNC_STAGES = 2;
endpackage

// *** verilog/fir_link_if.sv ***
interface fir_link_if;
	// synchronous sample side, bussed across a cascade
	logic go_in;
	logic go_out;
	logic go_oe;
	logic go_drive;
	logic [15:0] sample_port;
	logic [11:0] result_half;
	logic result_ready;
	logic [11:0] cascade_in_port;
	// asynchronous host register port, active-low strobes
	logic cs_n;
	logic strobe_n;
	logic write_n;
	logic [6:0] addr;
	logic [15:0] host_data_to_dev;
	logic [15:0] host_data_from_dev;
	logic host_data_oe;
	// a master device owns the initiate line; with all devices slave the outside source drives it
	wire go_line = go_oe ? go_out : go_drive;
	modport device (input go_line, output go_out, output go_oe, input sample_port, output result_half,
		output result_ready, input cascade_in_port, input cs_n, input strobe_n, input write_n, input addr,
		input host_data_to_dev, output host_data_from_dev, output host_data_oe);
	modport host (input go_line, output go_drive, output sample_port, input result_half, input result_ready,
		output cascade_in_port, output cs_n, output strobe_n, output write_n, output addr,
		output host_data_to_dev, input host_data_from_dev, input host_data_oe);
endinterface

// *** verilog/sync_stage.sv ***
// two-flop synchroniser for pins arriving from outside the clock domain
module sync_stage #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// a zero-width synchroniser has nothing to carry
	if (WIDTH < 1) begin : g_width_check
		$error("synchroniser width must be positive");
	end
	logic [WIDTH-1:0] meta_reg;
	// ------------------------------------------------------------
	// first flop feeds only the second
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// *** verilog/fir_device_end.sv ***
// Behaviour
// - slave samples initiate line before ready
// - sampled high initiate takes sample next edge
// - master raises initiate after input write
// - host waits for initiate low
// - sample port captured by clock and initiate
// - result out as halves, low first
// - cascade input two halves, low first
// - cascade word delayed 32 sample cycles
// - ready falls on low, rises on high
// - output registers valid at ready rise
// - strobe high ignores port, bus released
// - access needs select and strobe low
// - 128 words, write on strobe rise
// - register port independent of sample ports
// - group 64..79 mirrored up to 127
// - live bank readable, written when idle
// - shadow bank writable when idle, swap exchanges
// - controller settles initiate low 20 cycles
// - sample input register write only
// - output words sign-extended to 32 bits
// - config bit 10 selects fast output
// - same mode cascade-wide, 4-bit identical
// - size field sets sample spacing
// - source and role bits, master-port illegal
module fir_device_end #(
	parameter int TAPS = 32
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	fir_link_if.device link,
	input wire logic [23:0] array_sum_in,
	output logic [15:0] sample_out,
	output logic sample_take_out,
	output logic [15:0] coeff_live_out [TAPS],
	output logic illegal_mode_out
);
	import fir_link_pkg::*;
	// the delay line length is tied to the cascade timing
	if (TAPS != TAP_COUNT) begin : g_tap_check
		$error("tap count must match cascade delay");
	end
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic go_sync, cs_n_sync, strobe_n_sync, write_n_sync;
	logic [6:0] addr_sync;
	logic [15:0] wdata_sync;
	sync_stage #(.WIDTH(1 + 1 + 1 + 1 + 7 + 16)) host_sync (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.async_in({link.go_line, link.cs_n, link.strobe_n, link.write_n, link.addr, link.host_data_to_dev}),
		.sync_out({go_sync, cs_n_sync, strobe_n_sync, write_n_sync, addr_sync, wdata_sync})
	);
	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [15:0] shadow_coeff_bank [TAPS];
	logic [15:0] live_coeff_bank [TAPS];
	logic [15:0] static_config_reg, active_control_reg, test_control_reg, sample_input_reg;
	logic [23:0] result_reg;
	logic strobe_n_d_reg, word_pending_reg, busy_reg;
	logic [3:0] space_reg;
	logic [4:0] phase_reg;
	logic [HALF_WIDTH-1:0] casc_low_reg;
	logic [23:0] casc_delay [TAPS];
	logic [3:0] spacing;
	logic strobe_rise, wr_hit, ready_slot, take;
	logic [6:0] wa;
	assign strobe_rise = strobe_n_sync && !strobe_n_d_reg;
	assign wa = (addr_sync[6] ? (addr_sync & MIRROR_MASK) : addr_sync);
	assign wr_hit = strobe_rise && !cs_n_sync && !write_n_sync;
	assign spacing = {static_config_reg[CFG_SIZE_LSB+1:CFG_SIZE_LSB], 1'b0} + 4'h2;
	assign illegal_mode_out = static_config_reg[CFG_MASTER_BIT] && !static_config_reg[CFG_SOURCE_BIT];
	assign ready_slot = (space_reg == 4'h0);
	// slave takes when initiate seen high at the ready slot; master on own write
	assign take = ready_slot && (static_config_reg[CFG_MASTER_BIT] ? word_pending_reg : go_sync);
	// ------------------------------------------------------------
	// host writes: captured when the strobe returns high
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			strobe_n_d_reg <= 1'b1;
			static_config_reg <= STATIC_CONFIG_RESET;
			test_control_reg <= TEST_CONTROL_RESET;
			sample_input_reg <= 16'h0000;
		end else begin
			strobe_n_d_reg <= strobe_n_sync;
			if (wr_hit && wa == STATIC_CONFIG_ADDR)
				static_config_reg <= wdata_sync;
			if (wr_hit && wa == TEST_CONTROL_ADDR)
				test_control_reg <= wdata_sync;
			if (wr_hit && wa == SAMPLE_INPUT_ADDR)
				sample_input_reg <= wdata_sync;
		end
	end
	// coefficient banks; no reset, contents survive reset
	always_ff @(posedge ref_clk_in) begin
		for (int i = 0; i < TAPS; i++) begin
			if (busy_reg) begin
				shadow_coeff_bank[i] <= live_coeff_bank[i];
				live_coeff_bank[i] <= shadow_coeff_bank[i];
			end else begin
				if (wr_hit && wa == (SHADOW_BASE + 7'(i)))
					shadow_coeff_bank[i] <= wdata_sync;
				if (wr_hit && wa == (LIVE_BASE + 7'(i)))
					live_coeff_bank[i] <= wdata_sync;
			end
		end
	end
	assign coeff_live_out = live_coeff_bank;
	// swap request: set by write, cleared one cycle before the banks exchange; set wins
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			active_control_reg <= ACTIVE_CONTROL_RESET;
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= 1'b0;
			if (wr_hit && wa == ACTIVE_CONTROL_ADDR)
				active_control_reg <= wdata_sync;
			else if (active_control_reg[ACTIVE_SWAP_BIT] && ready_slot && !take) begin
				active_control_reg[ACTIVE_SWAP_BIT] <= 1'b0;
				busy_reg <= 1'b1;
			end else if (static_config_reg[CFG_SWAP_CONT_BIT] && take)
				busy_reg <= 1'b1;
		end
	end
	// ------------------------------------------------------------
	// sample input cycle, spacing and master initiate
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			space_reg <= 4'h0;
			word_pending_reg <= 1'b0;
			sample_out <= 16'h0000;
			sample_take_out <= 1'b0;
		end else begin
			sample_take_out <= take;
			if (wr_hit && wa == SAMPLE_INPUT_ADDR)
				word_pending_reg <= 1'b1;
			else if (take)
				word_pending_reg <= 1'b0;
			if (take) begin
				space_reg <= spacing - 4'h1;
				sample_out <= static_config_reg[CFG_SOURCE_BIT] ? sample_input_reg : link.sample_port;
			end else if (!ready_slot)
				space_reg <= space_reg - 4'h1;
		end
	end
	// master drives initiate high while its written word is pending
	assign link.go_out = word_pending_reg;
	assign link.go_oe = static_config_reg[CFG_MASTER_BIT];
	// ------------------------------------------------------------
	// cascade input, delay line and result multiplex
	// ------------------------------------------------------------
	logic fast_mode;
	logic [4:0] low_len;
	logic [23:0] new_result;
	assign fast_mode = static_config_reg[CFG_FAST_BIT];
	// fast: low half one cycle; normal: half the sample interval (4-bit same)
	assign low_len = fast_mode ? 5'h1 : {2'b00, spacing[3:1]};
	assign new_result = array_sum_in + casc_delay[TAPS-1];
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			phase_reg <= 5'h0;
			casc_low_reg <= '0;
			result_reg <= 24'h00_0000;
			link.result_half <= 12'h000;
			link.result_ready <= 1'b1;
		end else begin
			if (take) begin
				phase_reg <= 5'h1;
				casc_low_reg <= link.cascade_in_port;
				result_reg <= new_result;
				link.result_half <= new_result[HALF_WIDTH-1:0];
				link.result_ready <= 1'b0;
			end else if (phase_reg != 5'h0) begin
				if (phase_reg >= low_len) begin
					link.result_half <= result_reg[RESULT_WIDTH-1:HALF_WIDTH];
					link.result_ready <= 1'b1;
					phase_reg <= 5'h0;
				end else
					phase_reg <= phase_reg + 5'h1;
			end
		end
	end
	// delay line in one process: shift per sample cycle, load the paired word a cycle after the take
	// no reset, like the banks; a flush of 32 samples makes its contents defined
	always_ff @(posedge ref_clk_in) begin
		if (take) begin
			for (int i = 1; i < TAPS; i++)
				casc_delay[i] <= casc_delay[i-1];
		end else if (phase_reg == 5'h1)
			casc_delay[0] <= {link.cascade_in_port, casc_low_reg};
	end
	// ------------------------------------------------------------
	// host reads, bus released while strobe high
	// ------------------------------------------------------------
	always_comb begin
		link.host_data_from_dev = 16'h0000;
		if (wa < LIVE_BASE)
			link.host_data_from_dev = shadow_coeff_bank[wa[4:0]];
		else if (wa < STATIC_CONFIG_ADDR)
			link.host_data_from_dev = live_coeff_bank[wa[4:0]];
		else if (wa == STATIC_CONFIG_ADDR)
			link.host_data_from_dev = static_config_reg;
		else if (wa == ACTIVE_CONTROL_ADDR)
			link.host_data_from_dev = active_control_reg;
		else if (wa == TEST_CONTROL_ADDR)
			link.host_data_from_dev = test_control_reg;
		else if (wa == RESULT_LOW_ADDR)
			link.host_data_from_dev = result_reg[15:0];
		else if (wa == RESULT_HIGH_ADDR)
			link.host_data_from_dev = {{8{result_reg[23]}}, result_reg[23:16]};
	end
	assign link.host_data_oe = !strobe_n_sync && !cs_n_sync && write_n_sync;
endmodule

// *** verilog/fir_host_end.sv ***
// host side: drives samples, cascade input and the register port
module fir_host_end (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	fir_link_if.host link,
	input wire logic req_in,
	input wire logic req_write_in,
	input wire logic [6:0] req_addr_in,
	input wire logic [15:0] req_wdata_in,
	input wire logic [15:0] sample_in,
	input wire logic [11:0] cascade_in,
	input wire logic go_drive_in,
	output logic busy_out,
	output logic [15:0] rdata_out,
	output logic rdata_valid_out,
	output logic go_low_out
);
	import fir_link_pkg::*;
	logic [2:0] step_reg;
	logic go_s;
	sync_stage #(.WIDTH(1)) go_sync (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.async_in(link.go_line),
		.sync_out(go_s)
	);
	assign go_low_out = !go_s;
	assign busy_out = (step_reg != 3'h0);
	assign link.sample_port = sample_in;
	assign link.cascade_in_port = cascade_in;
	// external initiate for an all-slave cascade, bussed with the sample port
	assign link.go_drive = go_drive_in;
	// ------------------------------------------------------------
	// slow strobe cycle so the device's synchroniser sees it
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			step_reg <= 3'h0;
			link.cs_n <= 1'b1;
			link.strobe_n <= 1'b1;
			link.write_n <= 1'b1;
			link.addr <= 7'h00;
			link.host_data_to_dev <= 16'h0000;
			rdata_out <= 16'h0000;
			rdata_valid_out <= 1'b0;
		end else begin
			rdata_valid_out <= 1'b0;
			if (step_reg == 3'h0) begin
				if (req_in) begin
					link.cs_n <= 1'b0;
					link.strobe_n <= 1'b0;
					link.write_n <= !req_write_in;
					link.addr <= req_addr_in;
					link.host_data_to_dev <= req_wdata_in;
					step_reg <= 3'h1;
				end
			end else if (step_reg == 3'h6) begin
				if (link.host_data_oe) begin
					rdata_out <= link.host_data_from_dev;
					rdata_valid_out <= 1'b1;
				end
				link.strobe_n <= 1'b1;
				step_reg <= 3'h7;
			end else if (step_reg == 3'h7) begin
				if (!go_s || link.write_n)
					step_reg <= 3'h0;
				link.cs_n <= 1'b1;
			end else
				step_reg <= step_reg + 3'h1;
		end
	end
endmodule

// *** bench/fir_link_props.sv ***
module fir_link_props (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic go_line,
	input wire logic [11:0] result_half,
	input wire logic result_ready,
	input wire logic cs_n,
	input wire logic strobe_n,
	input wire logic write_n,
	input wire logic host_data_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!arst_n_in);
	// ------
	// result port: low half first, high half held
	// ------
	property p_ready_pulse;
		$fell(result_ready) |-> ##[1:4] $rose(result_ready);
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready stayed low too long");
	property p_high_hold;
		result_ready && $past(result_ready) |-> $stable(result_half);
	endproperty
	a_high_hold: assert property (p_high_hold) else $error("high half moved while ready");
	property p_half_step;
		$changed(result_half) |-> $changed(result_ready);
	endproperty
	a_half_step: assert property (p_half_step) else $error("half changed without ready edge");
	// ------
	// register port: bus driven only during a read
	// ------
	property p_bus_release;
		strobe_n [*4] |-> !host_data_oe;
	endproperty
	a_bus_release: assert property (p_bus_release) else $error("data bus driven while idle");
	property p_read_drive;
		$rose(host_data_oe) |-> write_n && !cs_n && !strobe_n;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("bus driven outside a read");
	// ------
	// initiate line: raised after a completed write, then a take
	// ------
	property p_go_after_write;
		$rose(go_line) |-> strobe_n;
	endproperty
	a_go_after_write: assert property (p_go_after_write) else $error("initiate rose before strobe end");
	property p_go_drop;
		$rose(go_line) |-> ##[1:16] !go_line;
	endproperty
	a_go_drop: assert property (p_go_drop) else $error("initiate stuck high");
	property p_go_take;
		$rose(go_line) |-> ##[1:20] $fell(result_ready);
	endproperty
	a_go_take: assert property (p_go_take) else $error("no output after initiate");
	c_output: cover property ($rose(result_ready));
	c_read: cover property ($rose(host_data_oe));
	c_go: cover property ($fell(go_line));
endmodule

// *** bench/cascadable_fir_io_and_host_port_tb_top.sv ***
module cascadable_fir_io_and_host_port_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import fir_link_pkg::*;
	logic ref_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic req_in = 1'b0;
	logic req_write_in = 1'b0;
	logic [6:0] req_addr_in = 7'h00;
	logic [15:0] req_wdata_in = 16'h0000;
	logic [15:0] sample_in = 16'h0000;
	logic [11:0] cascade_in = 12'h000;
	logic go_drive_in = 1'b0;
	logic [23:0] array_sum_in = 24'h00_0000;
	logic busy_out, rdata_valid_out, go_low_out, sample_take_out, illegal_mode_out;
	logic [15:0] rdata_out, sample_out, sample_cap;
	logic [15:0] coeff_live [32];
	logic prev_rdy = 1'b1;
	logic [11:0] lo_seen, hi_seen;
	int run_len = 0;
	int low_len = 0;
	int outs = 0;
	int err_total = 0;
	int checks_done = 0;
	// 250 MHz device clock
	always #2 ref_clk_in = ~ref_clk_in;
	fir_link_if link_bus ();
	fir_device_end fir_device_end_inst (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .link(link_bus.device),
		.array_sum_in(array_sum_in), .sample_out(sample_out), .sample_take_out(sample_take_out),
		.coeff_live_out(coeff_live), .illegal_mode_out(illegal_mode_out));
	fir_host_end fir_host_end_inst (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .link(link_bus.host),
		.req_in(req_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
		.sample_in(sample_in), .cascade_in(cascade_in), .busy_out(busy_out), .rdata_out(rdata_out),
		.go_drive_in(go_drive_in),
		.rdata_valid_out(rdata_valid_out), .go_low_out(go_low_out));
	fir_link_props fir_link_props_inst (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .go_line(link_bus.go_line),
		.result_half(link_bus.result_half), .result_ready(link_bus.result_ready), .cs_n(link_bus.cs_n),
		.strobe_n(link_bus.strobe_n), .write_n(link_bus.write_n), .host_data_oe(link_bus.host_data_oe));
	// output monitor: reads pre-edge values, so no race with the design
	always @(posedge ref_clk_in) begin
		if (sample_take_out === 1'b1)
			sample_cap <= sample_out;
		if (link_bus.result_ready === 1'b0) begin
			run_len <= run_len + 1;
			if (prev_rdy)
				lo_seen <= link_bus.result_half;
		end
		if (link_bus.result_ready === 1'b1 && !prev_rdy) begin
			hi_seen <= link_bus.result_half;
			low_len <= run_len;
			run_len <= 0;
			outs <= outs + 1;
		end
		prev_rdy <= link_bus.result_ready;
	end
	// ------
	// reporting
	// ------
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic hung(input string what);
		err_total++;
		$display("wrong value %s expected done seen timeout", what);
		report_and_stop();
	endtask
	// ------
	// register port access through the host end
	// ------
	task automatic access(input logic wr, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
		int i;
		q = 'x;
		@(posedge ref_clk_in);
		req_in <= 1'b1;
		req_write_in <= wr;
		req_addr_in <= a;
		req_wdata_in <= d;
		@(posedge ref_clk_in);
		req_in <= 1'b0;
		for (i = 0; i < 40; i++) begin
			@(posedge ref_clk_in);
			#1;
			if (rdata_valid_out === 1'b1)
				q = rdata_out;
			if (i > 0 && busy_out === 1'b0)
				break;
		end
		if (i == 40)
			hung("access");
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] q;
		access(1'b1, a, d, q);
	endtask
	task automatic rd(input string what, input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] q;
		access(1'b0, a, 16'h0000, q);
		check16(what, exp, q);
	endtask
	// one master-mode sample: write input register, wait for the output pair
	task automatic take(input logic [15:0] s, input logic [23:0] sum, input logic [11:0] casc);
		int n;
		int i;
		n = outs;
		@(posedge ref_clk_in);
		array_sum_in <= sum;
		cascade_in <= casc;
		wr(SAMPLE_INPUT_ADDR, s);
		for (i = 0; i < 200 && (outs <= n || go_low_out !== 1'b1); i++)
			@(posedge ref_clk_in);
		if (i == 200)
			hung("output pair");
		#1;
	endtask
	// one slave-mode sample: port word plus a one-cycle initiate pulse from outside
	task automatic slave_take(input logic [15:0] s, input logic [23:0] sum);
		int n;
		int i;
		n = outs;
		@(posedge ref_clk_in);
		sample_in <= s;
		array_sum_in <= sum;
		go_drive_in <= 1'b1;
		@(posedge ref_clk_in);
		go_drive_in <= 1'b0;
		for (i = 0; i < 200 && outs <= n; i++)
			@(posedge ref_clk_in);
		if (i == 200)
			hung("slave output");
		#1;
	endtask
	// ------
	// main sequence
	// ------
	logic [4:0] ends [2] = '{5'h00, 5'h1f};
	logic [15:0] modes [5] = '{16'h0403, 16'h0103, 16'h0203, 16'h0303, 16'h0703};
	logic [15:0] lens [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0001};
	initial begin
		logic [23:0] r;
		logic [23:0] sum;
		int n_outs;
		repeat (3) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		rd("static_config", STATIC_CONFIG_ADDR, STATIC_CONFIG_RESET);
		rd("active_control", ACTIVE_CONTROL_ADDR, ACTIVE_CONTROL_RESET);
		rd("test_control", TEST_CONTROL_ADDR, TEST_CONTROL_RESET);
		foreach (ends[j]) begin
			wr({2'b00, ends[j]}, {11'h080, ends[j]});
			wr({2'b01, ends[j]}, {11'h100, ends[j]});
			rd("shadow entry", {2'b00, ends[j]}, {11'h080, ends[j]});
			rd("live entry", {2'b01, ends[j]}, {11'h100, ends[j]});
			check16("live bank port", {11'h100, ends[j]}, coeff_live[ends[j]]);
		end
		wr(ACTIVE_CONTROL_ADDR, 16'h0001);
		rd("swap bit cleared", ACTIVE_CONTROL_ADDR, 16'h0000);
		foreach (ends[j]) begin
			rd("shadow after swap", {2'b00, ends[j]}, {11'h100, ends[j]});
			rd("live after swap", {2'b01, ends[j]}, {11'h080, ends[j]});
		end
		// master with port source through a mirrored address
		wr(7'h50, 16'h0001);
		rd("mirrored config", STATIC_CONFIG_ADDR, 16'h0001);
		rd("unused location", 7'h41, 16'h0000);
		check16("illegal flag", 16'h0001, {15'h0000, illegal_mode_out});
		wr(STATIC_CONFIG_ADDR, 16'h0003);
		repeat (SETTLE_CYCLES) @(posedge ref_clk_in);
		check16("illegal flag", 16'h0000, {15'h0000, illegal_mode_out});
		// flush 32 zero cascade words, inject one, expect it 32 takes later
		for (int k = 0; k < 66; k++) begin
			sum = {k[0] ? 8'hf3 : 8'h0c, 8'h5a, k[7:0]};
			r = sum + ((k == 64) ? 24'h00_a00a : 24'h00_0000);
			take({8'hc3, k[7:0]}, sum, (k == 32) ? 12'h00a : 12'h000);
			check16("taken sample", {8'hc3, k[7:0]}, sample_cap);
			if (k >= 32) begin
				check16("low half", {4'h0, r[11:0]}, {4'h0, lo_seen});
				check16("high half", {4'h0, r[23:12]}, {4'h0, hi_seen});
				rd("result low", RESULT_LOW_ADDR, r[15:0]);
				rd("result high", RESULT_HIGH_ADDR, {{8{r[23]}}, r[23:16]});
			end
		end
		// low-half length per size code and output mode
		foreach (modes[j]) begin
			wr(STATIC_CONFIG_ADDR, modes[j]);
			repeat (SETTLE_CYCLES) @(posedge ref_clk_in);
			take(16'h0001, 24'h00_0000, 12'h000);
			check16("low half length", lens[j], 16'(low_len));
		end
		// slave role, port source, continuous swap: the initiate comes from outside
		wr(STATIC_CONFIG_ADDR, 16'h0004);
		n_outs = outs;
		repeat (SETTLE_CYCLES) @(posedge ref_clk_in);
		check16("outputs while initiate low", 16'(n_outs), 16'(outs));
		slave_take(16'h5a3c, 24'h9b_7e21);
		check16("port sample", 16'h5a3c, sample_cap);
		check16("slave low half", 16'h0e21, {4'h0, lo_seen});
		check16("slave high half", 16'h09b7, {4'h0, hi_seen});
		check16("live after continuous swap", {11'h100, 5'h00}, coeff_live[0]);
		report_and_stop();
	end
endmodule
